/* File: verilog/sctf_framer.sv */
`timescale 1ns/1ps
`default_nettype none
module sctf_framer
    import sctf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] sampleA,
    input wire logic [63:0] sampleB,
    input wire logic [1:0] overRange,
    input wire logic [1:0] sysrefSeen,
    input wire logic [1:0] sigMonitor,
    input wire logic [1:0] fastDetect,
    output logic sampleReady,
    output logic [7:0] laneActive,
    output logic frameStart,
    output logic multiframeStart,
    output logic [79:0] serialLaneOut
);
    // ==========================================
    // helpers
    function automatic logic [15:0] fmtWord(
        input logic [15:0] s,
        input logic [2:0] c,
        input logic [15:0] t,
        input logic [4:0] n,
        input logic [1:0] cs);
        logic [15:0] w;
        int ci;
        begin
            w = 16'h0000;
            for (int k = 0; k < 16; k++) begin
                ci = k - int'(n);
                if (k < int'(n)) begin
                    w[15-k] = s[15-k];
                end else if (ci < int'(cs)) begin
                    w[15-k] = c[2-ci];
                end else begin
                    w[15-k] = t[15-k];
                end
            end
            fmtWord = w;
        end
    endfunction

    // msb first, state bit 0 is the newest scrambled bit
    function automatic logic [22:0] scramble(
        input logic [7:0] d,
        input logic [14:0] st);
        logic [14:0] s;
        logic [7:0] o;
        logic b;
        begin
            s = st;
            o = 8'h00;
            for (int i = 7; i >= 0; i--) begin
                b = d[i] ^ s[13] ^ s[14];
                s = {s[13:0], b};
                o[i] = b;
            end
            scramble = {s, o};
        end
    endfunction

    function automatic sctf_phase_e nextPh(
        input sctf_phase_e p,
        input logic wide,
        input logic mrg);
        begin
            case (p)
                PH_MSB_A: nextPh = wide ? PH_LSB_A :
                                   (mrg ? PH_MSB_B : PH_MSB_A);
                PH_LSB_A: nextPh = mrg ? PH_MSB_B : PH_MSB_A;
                PH_MSB_B: nextPh = wide ? PH_LSB_B : PH_MSB_A;
                PH_LSB_B: nextPh = PH_MSB_A;
                default: nextPh = PH_MSB_A;
            endcase
        end
    endfunction

    // ==========================================
    // register bus
    logic [SCTF_CTRL_W-1:0] ctrl_r;
    logic [SCTF_LINK_W-1:0] link_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdMux;
    logic hit;
    logic wrEn;
    logic resync;
    logic [31:0] statWord;

    assign wrEn = psel && penable && pready_r && pwrite;
    assign resync = wrEn && paddr == SCTF_LINK_OFS;

    // read decode, unmapped reads return zero with an error
    always_comb begin
        hit = 1'h1;
        case (paddr)
            SCTF_CTRL_OFS: rdMux = {24'h000000, ctrl_r};
            SCTF_LINK_OFS: rdMux = {13'h0000, link_r};
            SCTF_STAT_OFS: rdMux = statWord;
            default: begin
                rdMux = 32'h00000000;
                hit = 1'h0;
            end
        endcase
    end

    // one wait state; answer registered so pready is a flop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r <= 32'h00000000;
        end else if (ce) begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                prdata_r <= pwrite ? 32'h00000000 : rdMux;
                pslverr_r <= !hit || (pwrite && paddr == SCTF_STAT_OFS);
            end else begin
                pslverr_r <= 1'h0;
            end
        end
    end

    // writes land on the edge that samples pready high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= SCTF_CTRL_RST;
            link_r <= SCTF_LINK_RST;
        end else if (ce && wrEn) begin
            if (paddr == SCTF_CTRL_OFS) begin
                ctrl_r <= pwdata[SCTF_CTRL_W-1:0];
            end
            if (paddr == SCTF_LINK_OFS) begin
                link_r <= pwdata[SCTF_LINK_W-1:0];
            end
        end
    end

    // ==========================================
    // link parameter decode
    logic [1:0] lc;
    logic [1:0] mc;
    logic [2:0] fc;
    logic [2:0] kc;
    logic ws;
    logic [4:0] nBits;
    logic [1:0] csBits;
    logic [1:0] qc;
    logic merge;
    logic swap;
    logic scrEn;
    logic [2:0] laneCnt;
    logic [4:0] fLast;
    logic [4:0] kLast;
    logic [3:0] numSh;
    logic [3:0] denSh;
    logic [6:0] sPer;
    logic hdMode;
    logic cfgValid;

    always_comb begin
        lc = link_r[SCTF_L_LSB +: 2];
        mc = link_r[SCTF_M_LSB +: 2];
        fc = link_r[SCTF_F_LSB +: 3];
        ws = link_r[SCTF_WS_BIT];
        nBits = link_r[SCTF_N_LSB +: 5];
        csBits = link_r[SCTF_CS_LSB +: 2];
        kc = link_r[SCTF_K_LSB +: 3];
        qc = ctrl_r[SCTF_QC_LSB +: 2];
        merge = qc == SCTF_QC_MERGE;
        swap = qc == SCTF_QC_SWAP;
        scrEn = ctrl_r[SCTF_SCR_BIT];
        laneCnt = 3'h1 << lc;
        fLast = (5'h01 << fc) - 5'h01;
        kLast = {kc, 2'h3};
        // S = 8FL/(MN'), all factors powers of two
        numSh = 4'(fc) + 4'(lc) + 4'h3;
        denSh = 4'(mc) + (ws ? 4'h4 : 4'h3);
        sPer = (numSh >= denSh) ? 7'(8'h01 << (numSh - denSh)) : 7'h00;
        hdMode = (fc == 3'h0) && ws;
        // an unsupported set stops the lanes rather than send garbage
        cfgValid = (lc != 2'h3) && (fc <= 3'h4) && (numSh >= denSh) &&
                   (nBits >= 5'h07) && (nBits <= 5'h10) &&
                   (6'(nBits) + 6'(csBits) <= (ws ? 6'h10 : 6'h08)) &&
                   (!merge || lc == 2'h0);
        statWord = 32'h00000000;
        statWord[SCTF_S_LSB +: 7] = sPer;
        statWord[SCTF_HD_BIT] = hdMode;
        statWord[SCTF_VAL_BIT] = cfgValid;
        statWord[SCTF_CF_LSB +: 2] = SCTF_CF_VAL;
    end

    // ==========================================
    // octet phase and frame position
    sctf_phase_e ph_r;
    sctf_phase_e phNxt;
    logic [4:0] octPos_r;
    logic [4:0] frmCnt_r;
    logic frameEnd;
    logic mfEnd;
    logic sampleReady_r;

    assign phNxt = nextPh(ph_r, ws, merge);
    assign frameEnd = octPos_r == fLast;
    assign mfEnd = frameEnd && frmCnt_r == kLast;

    // link write restarts framing from a clean boundary
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ph_r <= PH_MSB_A;
            sampleReady_r <= 1'h0;
        end else if (ce) begin
            ph_r <= resync ? PH_MSB_A : phNxt;
            sampleReady_r <= !resync && nextPh(phNxt, ws, merge) == PH_MSB_A;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            octPos_r <= 5'h00;
            frmCnt_r <= 5'h00;
        end else if (ce) begin
            if (resync || frameEnd) begin
                octPos_r <= 5'h00;
            end else begin
                octPos_r <= octPos_r + 5'h01;
            end
            if (resync || mfEnd) begin
                frmCnt_r <= 5'h00;
            end else if (frameEnd) begin
                frmCnt_r <= frmCnt_r + 5'h01;
            end
        end
    end

    // ==========================================
    // sample capture and tail pattern
    logic [8:0] pn_r;
    logic [15:0] tailW;
    logic [2:0] ctlA;
    logic [2:0] ctlB;
    logic [15:0] wordA_r [0:3];
    logic [15:0] wordB_r [0:3];

    assign tailW = ctrl_r[SCTF_PN_BIT] ? {pn_r, pn_r[8:2]} : 16'h0000;
    assign ctlA = {overRange[0], sysrefSeen[0],
                   ctrl_r[SCTF_SIG_BIT] ? sigMonitor[0] : fastDetect[0]};
    assign ctlB = {overRange[1], sysrefSeen[1],
                   ctrl_r[SCTF_SIG_BIT] ? sigMonitor[1] : fastDetect[1]};

    // pattern steps once per captured sample set
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pn_r <= SCTF_PN_SEED;
        end else if (ce && sampleReady_r) begin
            pn_r <= {pn_r[7:0], pn_r[8] ^ pn_r[4]};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < SCTF_GRP; i++) begin
                wordA_r[i] <= 16'h0000;
                wordB_r[i] <= 16'h0000;
            end
        end else if (ce && sampleReady_r) begin
            for (int i = 0; i < SCTF_GRP; i++) begin
                wordA_r[i] <= fmtWord(sampleA[i*16 +: 16], ctlA, tailW,
                                      nBits, csBits);
                wordB_r[i] <= fmtWord(sampleB[i*16 +: 16], ctlB, tailW,
                                      nBits, csBits);
            end
        end
    end

    // ==========================================
    // per lane octet, scramble, alignment, encode
    logic [7:0] actV;
    logic phB;
    logic phMsb;

    assign phB = ph_r == PH_MSB_B || ph_r == PH_LSB_B;
    assign phMsb = ph_r == PH_MSB_A || ph_r == PH_MSB_B;

    for (genvar j = 0; j < SCTF_LANES; j++) begin : g_lane
        localparam int G = j / SCTF_GRP;
        localparam int IX = j % SCTF_GRP;
        logic useB;
        logic [15:0] w;
        logic [7:0] oct;
        logic [7:0] octTx;
        logic kSel;
        logic [22:0] scrRes;
        logic [14:0] scr_r;
        logic [7:0] last_r;

        // one bit per lane, so each lane drives only its own bit
        assign actV[j] = cfgValid &&
                         (merge ? (j == 0) : (3'(IX) < laneCnt));

        // lane mapping: low group A, high group B unless swapped
        always_comb begin
            useB = merge ? phB : ((G == 1) ? !swap : swap);
            if (useB) begin
                w = merge ? wordB_r[0] : wordB_r[IX];
            end else begin
                w = merge ? wordA_r[0] : wordA_r[IX];
            end
            oct = phMsb ? w[15:8] : w[7:0];
            scrRes = scramble(oct, scr_r);
            if (scrEn) begin
                octTx = scrRes[7:0];
                kSel = (frameEnd && octTx == SCTF_K28_7) ||
                       (mfEnd && octTx == SCTF_K28_3);
            end else begin
                kSel = frameEnd && oct == last_r;
                octTx = kSel ? (mfEnd ? SCTF_K28_3 : SCTF_K28_7) : oct;
            end
        end

        // raw last octet kept for the unscrambled repeat test
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                scr_r <= SCTF_SCR_SEED;
                last_r <= 8'h00;
            end else if (ce && actV[j]) begin
                if (scrEn) begin
                    scr_r <= scrRes[22:8];
                end
                if (frameEnd) begin
                    last_r <= oct;
                end
            end
        end

        sctf_enc8b10b u_enc (
            .core_clk(core_clk),
            .rstn(rstn),
            .ce(ce),
            .valid(actV[j]),
            .isK(kSel),
            .dIn(octTx),
            .symOut(serialLaneOut[j*10 +: 10])
        );

        kAtFrameEnd_a: assert property (
            @(posedge core_clk) disable iff (!rstn)
            ce && actV[j] && kSel |-> frameEnd &&
            (octTx == SCTF_K28_7 || (mfEnd && octTx == SCTF_K28_3)))
            else $error("alignment character off a frame end");
    end

    // ==========================================
    // outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            laneActive <= 8'h00;
            frameStart <= 1'h0;
            multiframeStart <= 1'h0;
        end else if (ce) begin
            laneActive <= actV;
            frameStart <= cfgValid && octPos_r == 5'h00;
            multiframeStart <= cfgValid && octPos_r == 5'h00 &&
                               frmCnt_r == 5'h00;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    assign sampleReady = sampleReady_r;

    // ==========================================
    // checks
    apbAnswer_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && psel && penable && !pready |=> pready)
        else $error("apb access not answered");

    apbPulse_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && pready |=> !pready)
        else $error("pready held beyond one cycle");

    derivedS_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        cfgValid |-> int'(sPer) * (1 << mc) * (ws ? 16 : 8) ==
                     8 * (1 << fc) * (1 << lc))
        else $error("derived samples per frame wrong");

    frameWrap_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && frameEnd |=> octPos_r == 5'h00)
        else $error("frame position did not wrap");

    msbFirst_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && sampleReady |=> ph_r == PH_MSB_A)
        else $error("sample did not start with msb octet");

    mergeOrder_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && merge && ws && ph_r == PH_LSB_A && !resync
        |=> ph_r == PH_MSB_B)
        else $error("merged lane skipped converter b");

    mfStart_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        multiframeStart |-> frameStart)
        else $error("multiframe start off a frame start");

    lanesIdle_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && !cfgValid |=> laneActive == 8'h00)
        else $error("lanes active with invalid link set");

    msbOctet_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && sampleReady && nBits == 5'h0E && csBits == 2'h0
        |=> wordA_r[0][15:2] == $past(sampleA[15:2]))
        else $error("sample bits misplaced in octets");
endmodule
`default_nettype wire

/* File: verilog/sctf_pkg.sv */
`default_nettype none
package sctf_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] SCTF_CTRL_OFS = 8'h00;
    localparam logic [7:0] SCTF_LINK_OFS = 8'h04;
    localparam logic [7:0] SCTF_STAT_OFS = 8'h08;
    // control fields
    localparam int SCTF_CTRL_W = 8;
    localparam int SCTF_SCR_BIT = 0;
    localparam int SCTF_PN_BIT = 1;
    localparam int SCTF_SIG_BIT = 2;
    localparam int SCTF_QC_LSB = 4;
    localparam logic [7:0] SCTF_CTRL_RST = 8'h01;
    // link fields
    localparam int SCTF_LINK_W = 19;
    localparam int SCTF_L_LSB = 0;
    localparam int SCTF_M_LSB = 2;
    localparam int SCTF_F_LSB = 4;
    localparam int SCTF_WS_BIT = 7;
    localparam int SCTF_N_LSB = 8;
    localparam int SCTF_CS_LSB = 13;
    localparam int SCTF_K_LSB = 16;
    localparam logic [18:0] SCTF_LINK_RST = 19'h70E96;
    // status fields
    localparam int SCTF_S_LSB = 0;
    localparam int SCTF_HD_BIT = 8;
    localparam int SCTF_VAL_BIT = 9;
    localparam int SCTF_CF_LSB = 12;
    localparam logic [1:0] SCTF_CF_VAL = 2'h0;
    // ==========================================
    // quick configuration codes
    localparam logic [1:0] SCTF_QC_SPLIT = 2'h0;
    localparam logic [1:0] SCTF_QC_MERGE = 2'h1;
    localparam logic [1:0] SCTF_QC_SWAP = 2'h2;
    // octet phase, one-hot
    typedef enum logic [3:0] {
        PH_MSB_A = 4'h1,
        PH_LSB_A = 4'h2,
        PH_MSB_B = 4'h4,
        PH_LSB_B = 4'h8
    } sctf_phase_e;
    // ==========================================
    // alignment characters and seeds
    localparam logic [7:0] SCTF_K28_3 = 8'h7C;
    localparam logic [7:0] SCTF_K28_7 = 8'hFC;
    localparam logic [14:0] SCTF_SCR_SEED = 15'h7FFF;
    localparam logic [8:0] SCTF_PN_SEED = 9'h1FF;
    localparam int SCTF_LANES = 8;
    localparam int SCTF_GRP = 4;
endpackage
`default_nettype wire

/* File: verilog/sctf_enc8b10b.sv */
`timescale 1ns/1ps
`default_nettype none
module sctf_enc8b10b
    import sctf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic valid,
    input wire logic isK,
    input wire logic [7:0] dIn,
    output logic [9:0] symOut
);
    // ==========================================
    // code tables, negative disparity forms
    localparam logic [5:0] T6 [0:31] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] T4 [0:7] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [31:0] UNB6 = 32'hE9818117;
    localparam logic [7:0] FLIP4 = 8'h99;
    localparam logic [7:0] UNB4 = 8'h91;
    localparam logic [5:0] K28_6B = 6'h0F;
    localparam logic [3:0] ALT7 = 4'h7;

    logic rd_r;
    logic rdMid;
    logic rdEnd;
    logic alt;
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] x;
    logic [2:0] y;

    // ==========================================
    // encode: balanced codes pass except D.07 and D.x.3, others follow disparity
    always_comb begin
        x = dIn[4:0];
        y = dIn[7:5];
        if (isK) begin
            c6 = rd_r ? ~K28_6B : K28_6B;
            rdMid = !rd_r;
        end else begin
            c6 = T6[x];
            if (rd_r && (UNB6[x] || x == 5'h07)) begin
                c6 = ~c6;
            end
            rdMid = UNB6[x] ? !rd_r : rd_r;
        end
        // alternate form keeps run length at five
        alt = (y == 3'h7) && (isK ||
              (!rdMid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
              (rdMid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        c4 = alt ? ALT7 : T4[y];
        if (rdMid && FLIP4[y]) begin
            c4 = ~c4;
        end
        rdEnd = UNB4[y] ? !rdMid : rdMid;
    end

    // registered symbol, bit 9 leaves first
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_r <= 1'h0;
            symOut <= 10'h000;
        end else if (ce) begin
            if (valid) begin
                rd_r <= rdEnd;
                symOut <= {c6, c4};
            end else begin
                symOut <= 10'h000;
            end
        end
    end

    symbolBalance_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        symOut != 10'h000 |-> $countones(symOut) inside {4, 5, 6})
        else $error("encoded symbol out of balance");
endmodule
`default_nettype wire

/* File: tb/sctf_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far-side receiver: follows lane 0 framing
module sctf_rx_model (
    input wire logic core_clk,
    input wire logic clr,
    input wire logic frameStart,
    input wire logic multiframeStart,
    input wire logic [9:0] lane0,
    output logic [9:0] msbSym,
    output int nFrm,
    output int nOdd
);
    logic [9:0] prevSym;
    // last symbol of a repeating frame must be an alignment character
    always @(posedge core_clk) begin
        prevSym <= lane0;
        if (clr) begin
            nFrm <= 0;
            nOdd <= 0;
        end else if (frameStart) begin
            nFrm <= nFrm + 1;
            msbSym <= lane0;
            if (multiframeStart) begin
                if (prevSym != 10'h0F3 && prevSym != 10'h30C) begin
                    nOdd <= nOdd + 1;
                end
            end else if (prevSym != 10'h0F8 && prevSym != 10'h307) begin
                nOdd <= nOdd + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/sctf_framer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sctf_framer_tb;
    import sctf_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [63:0] sampleA = 64'h0;
    logic [63:0] sampleB = 64'h0;
    logic [7:0] ctl = 8'h00;
    logic rnd = 1'b0;
    logic ce = 1'b1;
    logic clr = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, sampleReady, frameStart, multiframeStart;
    logic [7:0] laneActive;
    logic [79:0] serialLaneOut;
    logic [9:0] msbSym;
    logic [64:0] expQ[$];
    logic [64:0] note;
    logic [7:0] lanes [3] = '{8'h11, 8'h33, 8'hFF};
    logic [31:0] r;
    int nFrm, nOdd, nf, nm, ns;
    int n_errors = 0;
    int check_count = 0;

    sctf_framer u_dut (.core_clk(core_clk), .rstn(rstn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleA(sampleA), .sampleB(sampleB),
        .overRange(ctl[1:0]), .sysrefSeen(ctl[3:2]),
        .sigMonitor(ctl[5:4]), .fastDetect(ctl[7:6]),
        .sampleReady(sampleReady), .laneActive(laneActive),
        .frameStart(frameStart), .multiframeStart(multiframeStart),
        .serialLaneOut(serialLaneOut));
    sctf_rx_model u_rx (.core_clk(core_clk), .clr(clr),
        .frameStart(frameStart), .multiframeStart(multiframeStart),
        .lane0(serialLaneOut[9:0]), .msbSym(msbSym), .nFrm(nFrm),
        .nOdd(nOdd));

    // ==========================================
    // clock, stimulus and scoreboard
    always #2 core_clk = ~core_clk;
    // random traffic, or a fixed pattern so frame ends repeat
    always @(posedge core_clk) begin
        sampleA <= rnd ? {$urandom, $urandom} : {4{16'hFF00}};
        sampleB <= rnd ? {$urandom, $urandom} : 64'h0;
        ctl <= rnd ? 8'($urandom) : 8'h00;
    end
    // oldest note is judged when the slave answers
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1) begin
            note = expQ.pop_front();
            chk("prdata", prdata & note[63:32], note[31:0]);
            chk("pslverr", 32'(pslverr), 32'(note[64]));
        end
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        $display("watchdog expired");
        end_of_test();
    end

    // ==========================================
    // tasks
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one transfer; mask picks the read bits that are judged
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic [31:0] e,
        input logic err);
        expQ.push_back({err, m, e});
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    function automatic logic [31:0] link(input int l, input int k);
        link = 32'(SCTF_LINK_RST);
        link[1:0] = l[1:0];
        // octets per frame scale against lanes so S stays at two
        link[6:4] = 3'(3 - l);
        link[18:16] = k[2:0];
    endfunction
    task automatic count(input int cyc);
        nf = 0;
        nm = 0;
        ns = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            nf += int'(frameStart);
            nm += int'(multiframeStart);
            ns += int'(sampleReady);
        end
    endtask
    // lane 0 leading symbol must be one of the two disparity forms
    task automatic lane0(input logic [9:0] s0, input logic [9:0] s1);
        repeat (20) @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (200) @(posedge core_clk);
        chk("alignChars", 32'(nOdd), 0);
        chk("frames", 32'(nFrm > 90), 1);
        chk("msbSym", 32'(msbSym === s0 || msbSym === s1), 1);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        r = $urandom(32'h02B8);
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        apb(0, SCTF_CTRL_OFS, 0, 32'hFF, 32'h01, 0);
        apb(0, SCTF_LINK_OFS, 0, 32'h7FFFF, 32'h70E96, 0);
        apb(0, SCTF_STAT_OFS, 0, 32'h337F, 32'h0202, 0);
        apb(1, SCTF_STAT_OFS, 32'h0, 0, 0, 1);
        apb(0, 8'h0C, 0, 32'hFFFFFFFF, 0, 1);
        chk("laneActive", 32'(laneActive), 32'hFF);
        $display("reset and registers done");
        rnd <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            apb(1, SCTF_LINK_OFS, link(2, c), 0, 0, 0);
            count(32 * (c + 1));
            chk("mfStarts", 32'(nm), 4);
            chk("frameStarts", 32'(nf), 32'(16 * (c + 1)));
            chk("captures", 32'(ns), 32'(16 * (c + 1)));
        end
        // clock enable low must freeze the frame start and sample ready strobes
        ce <= 1'b0;
        count(40);
        chk("ceFreeze", 32'((nf == 0 || nf == 40) && ns % 40 == 0), 1);
        ce <= 1'b1;
        $display("multiframe lengths done");
        for (int l = 0; l < 3; l++) begin
            apb(1, SCTF_LINK_OFS, link(l, 7), 0, 0, 0);
            chk("laneActive", 32'(laneActive), 32'(lanes[l]));
        end
        r = $urandom;
        apb(1, SCTF_CTRL_OFS, r & 32'h07, 0, 0, 0);
        apb(0, SCTF_CTRL_OFS, 0, 32'hFF, r & 32'h07, 0);
        apb(1, SCTF_CTRL_OFS, 32'h10, 0, 0, 0);
        chk("badCfgLanes", 32'(laneActive), 0);
        chk("badCfgOut", 32'(serialLaneOut === 80'h0), 1);
        apb(1, SCTF_LINK_OFS, link(0, 7), 0, 0, 0);
        chk("mergeLanes", 32'(laneActive), 32'h01);
        count(128);
        chk("mergeCaptures", 32'(ns), 32);
        $display("lanes and quick modes done");
        rnd <= 1'b0;
        apb(1, SCTF_CTRL_OFS, 32'h20, 0, 0, 0);
        apb(1, SCTF_LINK_OFS, link(2, 7), 0, 0, 0);
        lane0(10'h274, 10'h18B);
        apb(1, SCTF_CTRL_OFS, 32'h00, 0, 0, 0);
        lane0(10'h2B1, 10'h14E);
        $display("framing content done");
        end_of_test();
    end
endmodule
`default_nettype wire
